// ---- fhp_flash_model.sv ----
// Purpose: Behavioural parallel NOR flash pin model for the host controller bench
// Assumes: Bottom boundary sector is the guarded one, any unguarded write programs one word
// Notes:   Pins polled every 10 ns, offset from the clock edges
`timescale 1ns/10ps
module fhp_flash_model
    import fhp_pkg::*;
#(
    parameter int unsigned       PROMPT_NS = 400,
    parameter int unsigned       SLOW_NS   = 4000,
    parameter int unsigned       REC_NS    = 1000,
    parameter int unsigned       ACC_NS    = 60,
    parameter logic [ADDR_W-1:0] GUARD_TOP = 26'h000ffff
)(
    input  wire logic              slow_i,
    input  wire logic              reset_n_i,
    input  wire logic              ce_n_i,
    input  wire logic              oe_n_i,
    input  wire logic              we_n_i,
    input  wire logic              wp_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] host_data_i,
    input  wire logic              host_oe_i,
    output logic      [DATA_W-1:0] bus_o,
    output logic                   ry_low_o
);
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    logic [DATA_W-1:0] word;
    logic              failed;
    logic              recov;
    logic              sel_rd;
    realtime           busy_until;
    realtime           rec_until;
    realtime           rd_since;

    initial begin
        failed     = 1'b0;
        busy_until = 0;
        rec_until  = 0;
        rd_since   = 0;
        bus_o      = '0;
        ry_low_o   = 1'b1;
    end

    // Reset aborts the algorithm and clears the failure status
    always @(negedge reset_n_i) begin
        failed     = 1'b0;
        busy_until = 0;
    end

    always @(posedge reset_n_i) begin
        rec_until = $realtime + REC_NS;
    end

    // Write strobe rise programs a word, guarded sector fails
    always @(posedge we_n_i) begin
        if (reset_n_i && !ce_n_i && $realtime >= rec_until) begin
            if (wp_n_i === 1'b0 && addr_i <= GUARD_TOP) begin
                failed = 1'b1;
            end else begin
                mem[addr_i] = host_data_i;
            end
            busy_until = $realtime + (slow_i ? SLOW_NS : PROMPT_NS);
        end
    end

    // Pin levels; a released bus shows a changing pattern
    initial begin
        #5;
        forever begin
            recov    = !reset_n_i || $realtime < rec_until;
            ry_low_o = recov || failed || $realtime < busy_until;
            sel_rd   = reset_n_i && !ce_n_i && !oe_n_i && we_n_i && !recov;
            if (!sel_rd) begin
                rd_since = $realtime;
            end
            word = mem.exists(addr_i) ? mem[addr_i] : 16'hffff;
            if (host_oe_i) begin
                bus_o = host_data_i;
            end else if (sel_rd && $realtime - rd_since >= ACC_NS) begin
                bus_o = word;
            end else begin
                bus_o = ~bus_o;
            end
            #10;
        end
    end
endmodule // fhp_flash_model

// ---- fhp_host.sv ----
// Purpose: Host controller driving the control pins of a parallel NOR flash
// Assumes: Single 25 MHz clock, pin inputs synchronised before use
// Notes:   Reads and writes are single word transfers on the user port
// What the document requires of device and host
// RULE1: Device returns to standby while reset low
// RULE2: Device transfers only while chip select low
// RULE3: Device drives data only when output enable low
// RULE4: Write strobe low means host to device
// RULE5: Guard low protects one boundary sector
// RULE6: Unconnected guard input reads as unprotected
// RULE7: Ready pin low while algorithm runs
// RULE8: Ready pin busy during power or hardware reset
// RULE9: Ready pin released when nothing active
// RULE10: Host pulls ready pin up, may wire-and
// RULE11: Trust ready only after last strobe or reset
// RULE12: Erase suspend reads ready unless programming
// RULE13: Failure keeps busy until status cleared, reset
// RULE14: Locked sector attempt counts as failure
// RULE15: Reset held long enough aborts, leaves overlay
// RULE16: Reset tristates outputs, clears status, idles controller
// RULE17: Chip select ignored during reset recovery
// RULE18: Host keeps chip select high during reset
// RULE19: Host re-issues operation cut by reset; this host only flags it on op_cut_o with done_o
// RULE20: Never output enable and write strobe together
`timescale 1ns/10ps
module fhp_host
    import fhp_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              req_i,
    input  wire logic              write_i,
    input  wire logic              last_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              hw_reset_i,
    input  wire logic              protect_i,
    output logic                   ready_o,
    output logic                   done_o,
    output logic      [DATA_W-1:0] rdata_o,
    output logic                   dev_busy_o,
    output logic                   op_cut_o,
    output logic                   flash_reset_n_o,
    output logic                   ce_n_o,
    output logic                   oe_n_o,
    output logic                   we_n_o,
    output logic                   wp_n_o,
    output logic      [ADDR_W-1:0] address_bus_o,
    output logic      [DATA_W-1:0] data_bus_o,
    output logic                   data_bus_oe_o,
    input  wire logic [DATA_W-1:0] data_bus_i,
    input  wire logic              op_in_progress_n_i
);

    fhp_state_t        state;
    fhp_state_t        next_state;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  next_cnt;
    logic              is_write;
    logic              next_is_write;
    logic              is_last;
    logic              next_is_last;
    logic              cut;
    logic              next_cut;
    logic              next_done;
    logic              next_op_cut;
    logic [DATA_W-1:0] next_rdata;
    logic              next_reset_n;
    logic              next_ce_n;
    logic              next_oe_n;
    logic              next_we_n;
    logic [ADDR_W-1:0] next_addr;
    logic [DATA_W-1:0] next_data;
    logic              next_doe;
    logic [SYNC_W-1:0] pins_s;
    logic              rdy_s;

    fhp_sync u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({op_in_progress_n_i, data_bus_i}),
        .sync_o  (pins_s)
    );
    // Pin reads high only if external pull-up is fitted
    assign rdy_s      = pins_s[RDY_BIT]; // RULE10
    assign ready_o    = (state == FHP_IDLE);
    assign dev_busy_o = !rdy_s;
    always_comb begin
        next_state    = state;
        next_cnt      = (cnt != '0) ? cnt - 1'b1 : cnt; // Counts run down, rest at zero
        next_is_write = is_write;
        next_is_last  = is_last;
        next_cut      = cut;
        next_done     = 1'b0;
        next_op_cut   = 1'b0;
        next_rdata    = rdata_o;
        next_reset_n  = flash_reset_n_o;
        next_ce_n     = ce_n_o;
        next_oe_n     = oe_n_o;
        next_we_n     = we_n_o;
        next_addr     = address_bus_o;
        next_data     = data_bus_o;
        next_doe      = data_bus_oe_o;
        if (hw_reset_i && (state == FHP_IDLE || state == FHP_WAIT)) begin
            // Abort any wait, device drops its operation
            next_cut     = (state == FHP_WAIT); // RULE19
            next_state   = FHP_RST_LOW; // RULE15
            next_cnt     = RST_LOW_CNT;
            next_reset_n = 1'b0; // RULE1
            next_ce_n    = 1'b1; // RULE18
            next_oe_n    = 1'b1;
            next_we_n    = 1'b1;
            next_doe     = 1'b0; // RULE16
        end else begin
            case (state)
                FHP_IDLE: begin
                    if (req_i) begin
                        next_state    = FHP_SETUP;
                        next_cnt      = SETUP_CNT;
                        next_is_write = write_i;
                        next_is_last  = last_i;
                        next_addr     = addr_i;
                        next_data     = wdata_i;
                        next_ce_n     = 1'b0; // RULE2
                        next_doe      = write_i; // RULE3
                    end
                end
                FHP_SETUP: begin
                    if (cnt == '0) begin
                        next_state = FHP_STROBE;
                        if (is_write) begin
                            next_cnt  = WRITE_CNT;
                            next_we_n = 1'b0; // RULE4
                        end else begin
                            next_cnt  = READ_CNT;
                            next_oe_n = 1'b0; // RULE20
                        end
                    end
                end
                FHP_STROBE: begin
                    if (cnt == '0) begin
                        next_state = FHP_HOLD;
                        next_cnt   = HOLD_CNT;
                        next_we_n  = 1'b1;
                        next_oe_n  = 1'b1;
                        if (!is_write) begin
                            next_rdata = pins_s[DATA_W-1:0];
                        end
                    end
                end
                FHP_HOLD: begin
                    if (cnt == '0) begin
                        next_ce_n = 1'b1;
                        next_doe  = 1'b0;
                        if (is_write && is_last) begin
                            next_state = FHP_WAIT; // RULE11
                            next_cnt   = SETTLE_CNT;
                        end else begin
                            next_state = FHP_IDLE;
                            next_done  = 1'b1;
                        end
                    end
                end
                FHP_WAIT: begin
                    // Busy covers algorithms, resets and failures alike
                    if (cnt == '0 && rdy_s) begin // RULE7 RULE8 RULE9 RULE12 RULE13 RULE14
                        next_state  = FHP_IDLE;
                        next_done   = 1'b1;
                        next_op_cut = cut;
                        next_cut    = 1'b0;
                    end
                end
                FHP_RST_LOW: begin
                    if (cnt == '0) begin
                        next_state   = FHP_RST_REC;
                        next_cnt     = RST_REC_CNT;
                        next_reset_n = 1'b1;
                    end
                end
                FHP_RST_REC: begin
                    // Chip select stays high through recovery
                    if (cnt == '0) begin // RULE17
                        next_state   = FHP_WAIT;
                        next_cnt     = SETTLE_CNT;
                        next_is_last = 1'b1;
                    end
                end
                default: begin
                    next_state = FHP_IDLE;
                    next_ce_n  = 1'b1;
                    next_oe_n  = 1'b1;
                    next_we_n  = 1'b1;
                    next_doe   = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state           <= FHP_RST_LOW;
            cnt             <= RST_LOW_CNT;
            is_write        <= 1'b0;
            is_last         <= 1'b0;
            cut             <= 1'b0;
            done_o          <= 1'b0;
            op_cut_o        <= 1'b0;
            rdata_o         <= '0;
            flash_reset_n_o <= 1'b0;
            ce_n_o          <= 1'b1;
            oe_n_o          <= 1'b1;
            we_n_o          <= 1'b1;
            address_bus_o   <= '0;
            data_bus_o      <= '0;
            data_bus_oe_o   <= 1'b0;
            wp_n_o          <= 1'b1;
        end else begin
            state           <= next_state;
            cnt             <= next_cnt;
            is_write        <= next_is_write;
            is_last         <= next_is_last;
            cut             <= next_cut;
            done_o          <= next_done;
            op_cut_o        <= next_op_cut;
            rdata_o         <= next_rdata;
            flash_reset_n_o <= next_reset_n;
            ce_n_o          <= next_ce_n;
            oe_n_o          <= next_oe_n;
            we_n_o          <= next_we_n;
            address_bus_o   <= next_addr;
            data_bus_o      <= next_data;
            data_bus_oe_o   <= next_doe;
            wp_n_o          <= !protect_i; // RULE5 RULE6
        end
    end
    // Helper: length of the current reset low pulse
    logic [CNT_W-1:0] low_len;
    always_ff @(posedge clk_i) begin
        if (rst_i || flash_reset_n_o) begin
            low_len <= '0;
        end else begin
            low_len <= low_len + 1'b1;
        end
    end
    property p_oe_we_excl;
        @(posedge clk_i) disable iff (rst_i) !(!oe_n_o && !we_n_o);
    endproperty
    a_oe_we_excl: assert property (p_oe_we_excl) else $error("oe and we low together"); // RULE20
    property p_ce_high_in_reset;
        @(posedge clk_i) disable iff (rst_i)
            (!flash_reset_n_o || state == FHP_RST_REC) |-> ce_n_o;
    endproperty
    a_ce_high_in_reset: assert property (p_ce_high_in_reset) else $error("ce low in reset"); // RULE18
    property p_reset_len;
        @(posedge clk_i) disable iff (rst_i)
            $rose(flash_reset_n_o) |-> (low_len >= CNT_W'(RESET_PULSE_CYC));
    endproperty
    a_reset_len: assert property (p_reset_len) else $error("reset pulse too short"); // RULE15
    property p_recovery_len;
        @(posedge clk_i) disable iff (rst_i)
            $rose(flash_reset_n_o) |-> (state == FHP_RST_REC && ce_n_o)[*8];
    endproperty
    a_recovery_len: assert property (p_recovery_len) else $error("recovery cut short"); // RULE17
    property p_drive_only_oe_high;
        @(posedge clk_i) disable iff (rst_i) data_bus_oe_o |-> oe_n_o;
    endproperty
    a_drive_only_oe_high: assert property (p_drive_only_oe_high) else $error("bus contention"); // RULE3
    property p_we_drives;
        @(posedge clk_i) disable iff (rst_i) !we_n_o |-> (data_bus_oe_o && !ce_n_o);
    endproperty
    a_we_drives: assert property (p_we_drives) else $error("write without data"); // RULE4
    property p_strobe_needs_ce;
        @(posedge clk_i) disable iff (rst_i) (!oe_n_o || !we_n_o) |-> !ce_n_o;
    endproperty
    a_strobe_needs_ce: assert property (p_strobe_needs_ce) else $error("strobe without ce"); // RULE2
    property p_guard;
        @(posedge clk_i) disable iff (rst_i) ##1 (wp_n_o == !$past(protect_i));
    endproperty
    a_guard: assert property (p_guard) else $error("guard pin wrong"); // RULE5
    property p_wait_done_ready;
        @(posedge clk_i) disable iff (rst_i)
            ($past(state) == FHP_WAIT && state == FHP_IDLE) |-> ($past(rdy_s) && done_o);
    endproperty
    a_wait_done_ready: assert property (p_wait_done_ready) else $error("done while busy"); // RULE11
    property p_last_write_waits;
        @(posedge clk_i) disable iff (rst_i)
            (state == FHP_HOLD && cnt == '0 && is_write && is_last && !hw_reset_i)
            |=> (state == FHP_WAIT) [*2];
    endproperty
    a_last_write_waits: assert property (p_last_write_waits) else $error("no ready wait"); // RULE11
    c_read: cover property (@(posedge clk_i) disable iff (rst_i)
        !oe_n_o ##[1:20] (done_o && !is_write));
    c_write: cover property (@(posedge clk_i) disable iff (rst_i)
        !we_n_o ##[1:100] (done_o && is_write));
    c_reset: cover property (@(posedge clk_i) disable iff (rst_i)
        $fell(flash_reset_n_o) ##[1:100] done_o);
    c_cut: cover property (@(posedge clk_i) disable iff (rst_i) op_cut_o);
endmodule // fhp_host

// ---- fhp_pkg.sv ----
// Purpose: Shared constants and types for the flash pin controller
// Assumes: 25 MHz system clock, x16 flash with open-drain ready pin
// Notes:   Pin timing figures are plain defaults, adjust per part
package fhp_pkg;

    localparam int unsigned ADDR_W          = 26;
    localparam int unsigned DATA_W          = 16;
    localparam int unsigned SYNC_W          = DATA_W + 1;
    localparam int unsigned CNT_W           = 8;

    localparam int unsigned CLK_PERIOD_NS   = 40;
    localparam int unsigned RESET_PULSE_NS  = 500;
    localparam int unsigned RECOVERY_NS     = 1000;
    localparam int unsigned SETUP_NS        = 40;
    localparam int unsigned ACCESS_NS       = 120;
    localparam int unsigned WE_PULSE_NS     = 80;
    localparam int unsigned HOLD_NS         = 40;
    localparam int unsigned SETTLE_NS       = 200;

    // Least times, rounded up to whole cycles
    localparam int unsigned RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RECOVERY_CYC    = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETUP_CYC       = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ACCESS_CYC      = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WE_PULSE_CYC    = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HOLD_CYC        = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETTLE_CYC      = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SYNC_STAGES     = 2;

    localparam logic [CNT_W-1:0] RST_LOW_CNT  = CNT_W'(RESET_PULSE_CYC - 1);
    localparam logic [CNT_W-1:0] RST_REC_CNT  = CNT_W'(RECOVERY_CYC - 1);
    localparam logic [CNT_W-1:0] SETUP_CNT    = CNT_W'(SETUP_CYC - 1);
    localparam logic [CNT_W-1:0] READ_CNT     = CNT_W'(ACCESS_CYC + SYNC_STAGES - 1);
    localparam logic [CNT_W-1:0] WRITE_CNT    = CNT_W'(WE_PULSE_CYC - 1);
    localparam logic [CNT_W-1:0] HOLD_CNT     = CNT_W'(HOLD_CYC - 1);
    localparam logic [CNT_W-1:0] SETTLE_CNT   = CNT_W'(SETTLE_CYC + SYNC_STAGES - 1);

    localparam int unsigned RDY_BIT         = DATA_W;

    typedef enum logic [2:0] {
        FHP_IDLE    = 3'h0,
        FHP_SETUP   = 3'h1,
        FHP_STROBE  = 3'h3,
        FHP_HOLD    = 3'h2,
        FHP_WAIT    = 3'h6,
        FHP_RST_LOW = 3'h4,
        FHP_RST_REC = 3'h5
    } fhp_state_t;

endpackage

// ---- fhp_sync.sv ----
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Bits are independent levels or stable while sampled
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
module fhp_sync
    import fhp_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic [SYNC_W-1:0] async_i,
    output logic      [SYNC_W-1:0] sync_o
);

    logic [SYNC_W-1:0] stage1;
    logic [SYNC_W-1:0] stage2;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            stage1 <= async_i;
            stage2 <= stage1;
        end
    end

    assign sync_o = stage2;

endmodule // fhp_sync

// ---- test_fhp_host.sv ----
// Purpose: Self-checking bench for the flash host pin controller
// Assumes: Flash model on the far side, ready pin pulled up here
// Notes:   Inputs driven by non-blocking assignment at the rising edge
`timescale 1ns/10ps
`define CHK(got, exp, msg) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            n_errors++; \
            $display("MISMATCH %0t %s", $time, msg); \
        end \
    end
module test_fhp_host
    import fhp_pkg::*;
;
    localparam logic [ADDR_W-1:0] A0 = 26'h0234567;
    localparam logic [ADDR_W-1:0] A1 = 26'h3ffffff;
    localparam logic [ADDR_W-1:0] A2 = 26'h1000000;
    localparam logic [ADDR_W-1:0] A3 = 26'h0000010;

    logic              clk_i, rst_i, req_i, write_i, last_i, hw_reset_i, protect_i, slow;
    logic [ADDR_W-1:0] addr_i, address_bus_o;
    logic [DATA_W-1:0] wdata_i, rdata_o, data_bus_o, bus;
    logic              ready_o, done_o, dev_busy_o, op_cut_o, flash_reset_n_o;
    logic              ce_n_o, oe_n_o, we_n_o, wp_n_o, data_bus_oe_o, ry_low, ry_pin;
    int                n_errors, check_count, low_cyc;

    assign ry_pin = ry_low ? 1'b0 : 1'b1;

    fhp_host dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .write_i(write_i),
        .last_i(last_i), .addr_i(addr_i), .wdata_i(wdata_i), .hw_reset_i(hw_reset_i),
        .protect_i(protect_i), .ready_o(ready_o), .done_o(done_o), .rdata_o(rdata_o),
        .dev_busy_o(dev_busy_o), .op_cut_o(op_cut_o), .flash_reset_n_o(flash_reset_n_o),
        .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o), .wp_n_o(wp_n_o),
        .address_bus_o(address_bus_o), .data_bus_o(data_bus_o),
        .data_bus_oe_o(data_bus_oe_o), .data_bus_i(bus), .op_in_progress_n_i(ry_pin));

    fhp_flash_model partner (.slow_i(slow), .reset_n_i(flash_reset_n_o), .ce_n_i(ce_n_o),
        .oe_n_i(oe_n_o), .we_n_i(we_n_o), .wp_n_i(wp_n_o), .addr_i(address_bus_o),
        .host_data_i(data_bus_o), .host_oe_i(data_bus_oe_o), .bus_o(bus), .ry_low_o(ry_low));

    always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;

    task automatic close_out();
        if (n_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Pin monitors
    always @(negedge clk_i) begin
        if (!rst_i) begin
            `CHK(oe_n_o | we_n_o, 1'b1, "read and write strobes low together")
            `CHK(oe_n_o | ~data_bus_oe_o, 1'b1, "host drives bus during read")
            `CHK(flash_reset_n_o | ce_n_o, 1'b1, "select low during reset")
        end
    end

    always @(posedge clk_i) begin
        if (flash_reset_n_o === 1'b0) begin
            low_cyc <= low_cyc + 1;
        end else if (low_cyc != 0) begin
            `CHK(low_cyc >= RESET_PULSE_CYC, 1'b1, "reset pulse too short")
            low_cyc <= 0;
        end
    end

    task automatic wait_done(input int lim, output logic got, output logic busy,
                             output logic cut);
        got  = 1'b0;
        busy = 1'b0;
        cut  = 1'b0;
        for (int i = 0; i < lim && !got; i++) begin
            @(posedge clk_i);
            if (dev_busy_o === 1'b1) begin
                busy = 1'b1;
            end
            if (done_o === 1'b1) begin
                got = 1'b1;
                cut = (op_cut_o === 1'b1);
            end
        end
    endtask

    task automatic xfer(input logic wr, input logic lst, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        while (ready_o !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        req_i   <= 1'b1;
        write_i <= wr;
        last_i  <= lst;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clk_i);
        req_i <= 1'b0;
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        logic got, busy, cut;
        xfer(1'b0, 1'b0, a, 16'h0000);
        wait_done(20, got, busy, cut);
        `CHK(rdata_o, exp, "read data")
    endtask

    task automatic hw_pulse();
        hw_reset_i <= 1'b1;
        @(posedge clk_i);
        hw_reset_i <= 1'b0;
    endtask

    task automatic t_power_up();
        logic got, busy, cut;
        wait_done(200, got, busy, cut);
        `CHK(got & busy, 1'b1, "no busy or done at start-up")
        `CHK(ready_o, 1'b1, "not ready after start-up")
    endtask

    task automatic t_write_read();
        logic got, busy, cut;
        slow <= 1'b1;
        xfer(1'b1, 1'b0, A0, 16'h5a3c);
        wait_done(20, got, busy, cut);
        `CHK(got, 1'b1, "short write not done")
        xfer(1'b1, 1'b1, A1, 16'hc3a5);
        wait_done(400, got, busy, cut);
        `CHK(busy, 1'b1, "no busy during program")
        `CHK(got, 1'b1, "last write not done")
        `CHK(dev_busy_o, 1'b0, "busy after ready")
        rd_chk(A0, 16'h5a3c);
        rd_chk(A1, 16'hc3a5);
        rd_chk(A2, 16'hffff);
    endtask

    task automatic t_guard();
        logic got, busy, cut;
        protect_i <= 1'b1;
        slow      <= 1'b0;
        @(posedge clk_i);
        @(posedge clk_i);
        `CHK(wp_n_o, 1'b0, "guard pin not low")
        xfer(1'b1, 1'b1, A3, 16'h1234);
        wait_done(300, got, busy, cut);
        `CHK(got, 1'b0, "failed write reported done")
        `CHK(dev_busy_o, 1'b1, "failed write not busy")
        hw_pulse();
        wait_done(100, got, busy, cut);
        `CHK(got & cut & busy, 1'b1, "abort not flagged")
        `CHK(dev_busy_o, 1'b0, "busy after reset")
        rd_chk(A3, 16'hffff);
        protect_i <= 1'b0;
        xfer(1'b1, 1'b1, A3, 16'h1234);
        wait_done(100, got, busy, cut);
        `CHK(got, 1'b1, "unguarded write not done")
        rd_chk(A3, 16'h1234);
    endtask

    task automatic t_idle_reset();
        logic got, busy, cut;
        hw_pulse();
        wait_done(100, got, busy, cut);
        `CHK({got, cut}, 2'b10, "idle reset flags")
        rd_chk(A1, 16'hc3a5);
    endtask

    initial begin
        #(CLK_PERIOD_NS * 6000);
        n_errors++;
        close_out();
    end

    initial begin
        clk_i       = 1'b0;
        rst_i       = 1'b1;
        req_i       = 1'b0;
        write_i     = 1'b0;
        last_i      = 1'b0;
        addr_i      = '0;
        wdata_i     = '0;
        hw_reset_i  = 1'b0;
        protect_i   = 1'b0;
        slow        = 1'b0;
        n_errors    = 0;
        check_count = 0;
        low_cyc     = 0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_power_up();
        t_write_read();
        t_guard();
        t_idle_reset();
        close_out();
    end
endmodule // test_fhp_host
